// file: design/clk_pwr_pkg.sv
// Constants, register map and field layout for the clock and power control block.
// Operation
// RL1 - Core clock is PLL clock over two-to-divider
// RL2 - PLL locks crystal multiple for 4.096 MHz
// RL3 - Metering clock fixed at PLL over five
// RL4 - Power control write needs key 0xA7 first
// RL5 - Timekeeping writes need key 0xEA first
// RL6 - Lock loss resets core, sets flag bit4
// RL7 - Acknowledge bit clears the lock-loss flag
// RL8 - Acknowledge at bit 7, others reserved zero
// RL9 - Bit 6 powers down metering circuitry
// RL10 - Bit 4 shuts core in saving state one
// RL11 - Software keeps power control bit 5 zero
// RL12 - Rx wake from state two sets bit7
// RL13 - Bit 6 reports main or battery supply
// RL14 - Bit 5 set while main supply acceptable
// RL15 - Bit 3 keeps reference alive in state two
// RL16 - Software keeps peripheral config bit 2 zero
// RL17 - Bits 1:0 select Rx pin function
// RL18 - Software clears key after timekeeping write
// RL19 - Key consumed by first protected write; the code spends it on any write other than a new key
package clk_pwr_pkg;
   localparam logic [7:0] UNLOCK_KEY_ADDR = 8'hc1;
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'hc5;
   localparam logic [7:0] PERIPHERAL_CONFIG_CONFIG_ADDR = 8'hf4;
   localparam logic [7:0] ADC_START_ADDR = 8'hd8;
   localparam logic [7:0] KEY_POWER = 8'ha7;
   localparam logic [7:0] KEY_TIME = 8'hea;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h82;
   localparam logic [7:0] POWER_CONTROL_WMASK = 8'h57;
   localparam int PC_METER_BIT = 6;
   localparam int PC_CORE_OFF_BIT = 4;
   localparam int PC_DIV_LSB = 0;
   localparam int PC_DIV_W = 3;
   localparam int PF_RX_WAKE_BIT = 7;
   localparam int PF_SOURCE_BIT = 6;
   localparam int PF_SUPPLY_OK_BIT = 5;
   localparam int PF_LOCK_LOSS_BIT = 4;
   localparam int PF_REF_KEEP_BIT = 3;
   localparam int PF_RX_FN_LSB = 0;
   localparam int ACK_BIT = 7;
   localparam logic [1:0] RX_FN_GPIO = 2'h0;
   localparam logic [1:0] RX_FN_RX = 2'h1;
   localparam logic [1:0] RX_FN_RX_WAKE = 2'h3;
   localparam int METER_DIVIDE = 5;
   localparam real PLL_MHZ = 4.096;
   typedef enum logic [1:0] {
      KEY_NONE_ST = 2'b00,
      KEY_POWER_ST = 2'b01,
      KEY_TIME_ST = 2'b10
   } key_state_type;
endpackage : clk_pwr_pkg

// file: design/clk_div_if.sv
// Interface carrying divider settings and derived clock enables.
`timescale 1ns/10ps
interface clk_div_if;
   logic [2:0] divider;
   logic core_tick;
   logic meter_tick;
   modport ctrl (output divider, input core_tick, meter_tick);
   modport gen (input divider, output core_tick, meter_tick);
endinterface : clk_div_if

// file: design/clk_divider.sv
// Core and metering clock tick generator running from the PLL clock.
`timescale 1ns/10ps
module clk_divider #(
   parameter int DIV_W = 3
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   clk_div_if.gen div
);
   import clk_pwr_pkg::*;
   localparam int CNT_W = (1 << DIV_W) - 1;
   logic [CNT_W-1:0] core_cnt_reg;
   logic [2:0] meter_cnt_reg;
   logic [CNT_W-1:0] core_mask;
   logic meter_wrap;
   // The counter width grows as two to the field width, so wide fields are refused.
   if (DIV_W < 1 || DIV_W > 4) begin : g_bad_width
      $error("Divider width out of range.");
   end
   assign core_mask = CNT_W'((1 << div.divider) - 1);
   assign meter_wrap = (meter_cnt_reg == 3'(METER_DIVIDE - 1));
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         core_cnt_reg <= '0;
         meter_cnt_reg <= '0;
         div.core_tick <= 1'b0;
         div.meter_tick <= 1'b0;
      end else begin
         // Counter masks to the current setting, so a divider change takes effect at once.
         core_cnt_reg <= (core_cnt_reg + 1'b1) & core_mask; // RL1
         div.core_tick <= ((core_cnt_reg & core_mask) == core_mask); // RL1
         meter_cnt_reg <= meter_wrap ? 3'h0 : meter_cnt_reg + 3'h1; // RL3
         div.meter_tick <= meter_wrap; // RL3
      end
   end
endmodule : clk_divider

// file: design/clk_pwr_ctrl.sv
// Clock and power control block: key-protected registers, lock supervision and clock ticks.
`timescale 1ns/10ps
module clk_pwr_ctrl (
   // Clock and reset, clock is the locked PLL output.
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   // Analog and pin status.
   input wire logic pll_locked_i,
   input wire logic supply_on_main_i,
   input wire logic supply_ok_i,
   input wire logic rx_wake_event_i,
   input wire logic in_state_one_i,
   input wire logic in_state_two_i,
   input wire logic time_reg_sel_i,
   // Control outputs.
   output logic core_clk_en_o,
   output logic meter_clk_en_o,
   output logic [2:0] core_divider_field_o,
   output logic metering_shutdown_o,
   output logic core_shutdown_o,
   output logic reference_keep_alive_o,
   output logic [1:0] rx_pin_function_o,
   output logic time_write_en_o,
   output logic mcu_reset_o
);
   import clk_pwr_pkg::*;
   clk_div_if div ();
   key_state_type key_reg, key_next;
   logic [7:0] power_control_reg;
   logic rx_wake_flag_reg;
   logic lock_loss_flag_reg;
   logic ref_keep_reg;
   logic [1:0] rx_fn_reg;
   logic lock_seen_reg;
   logic wr_key, wr_pc, wr_pf, wr_ack, wr_time;
   logic pc_ok, time_ok, lock_lost, ack_clear;
   logic [7:0] pf_value, rdata_next;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction : hit

   assign wr_key = reg_we_i && hit(reg_addr_i, UNLOCK_KEY_ADDR);
   assign wr_pc = reg_we_i && hit(reg_addr_i, POWER_CONTROL_ADDR);
   assign wr_pf = reg_we_i && hit(reg_addr_i, PERIPHERAL_CONFIG_CONFIG_ADDR);
   assign wr_ack = reg_we_i && hit(reg_addr_i, ADC_START_ADDR);
   assign wr_time = reg_we_i && time_reg_sel_i;
   assign pc_ok = wr_pc && (key_reg == KEY_POWER_ST); // RL4
   assign time_ok = wr_time && (key_reg == KEY_TIME_ST); // RL5
   // Lock loss counts only after lock was first reached, so power-up does not flag it.
   assign lock_lost = lock_seen_reg && !pll_locked_i; // RL6 RL2
   assign ack_clear = wr_ack && reg_wdata_i[ACK_BIT]; // RL7 RL8

   // Any other write spends the key, so only the directly following write is granted.
   always_comb begin
      key_next = key_reg;
      if (wr_key) begin
         if (reg_wdata_i == KEY_POWER) key_next = KEY_POWER_ST; // RL4
         else if (reg_wdata_i == KEY_TIME) key_next = KEY_TIME_ST; // RL5
         else key_next = KEY_NONE_ST; // RL18
      end else if (reg_we_i) begin
         key_next = KEY_NONE_ST; // RL19
      end
   end

   always_comb begin
      pf_value = 8'h00;
      pf_value[PF_RX_WAKE_BIT] = rx_wake_flag_reg; // RL12
      pf_value[PF_SOURCE_BIT] = supply_on_main_i; // RL13
      pf_value[PF_SUPPLY_OK_BIT] = supply_ok_i; // RL14
      pf_value[PF_LOCK_LOSS_BIT] = lock_loss_flag_reg; // RL6
      pf_value[PF_REF_KEEP_BIT] = ref_keep_reg; // RL15
      pf_value[PF_RX_FN_LSB +: 2] = rx_fn_reg; // RL17
   end

   always_comb begin
      unique case (1'b1)
         hit(reg_addr_i, UNLOCK_KEY_ADDR): rdata_next = (key_reg == KEY_POWER_ST) ? KEY_POWER :
            (key_reg == KEY_TIME_ST) ? KEY_TIME : KEY_RESET;
         hit(reg_addr_i, POWER_CONTROL_ADDR): rdata_next = power_control_reg;
         hit(reg_addr_i, PERIPHERAL_CONFIG_CONFIG_ADDR): rdata_next = pf_value;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_reg <= KEY_NONE_ST;
         power_control_reg <= POWER_CONTROL_RESET;
         ref_keep_reg <= 1'b0;
         rx_fn_reg <= RX_FN_GPIO;
         lock_seen_reg <= 1'b0;
      end else begin
         key_reg <= key_next;
         if (pc_ok)
            power_control_reg <= (reg_wdata_i & POWER_CONTROL_WMASK)
               | (POWER_CONTROL_RESET & ~POWER_CONTROL_WMASK); // RL11
         if (wr_pf) begin
            ref_keep_reg <= reg_wdata_i[PF_REF_KEEP_BIT]; // RL15
            rx_fn_reg <= reg_wdata_i[PF_RX_FN_LSB +: 2]; // RL17
         end
         lock_seen_reg <= lock_seen_reg ? 1'b1 : pll_locked_i;
      end
   end

   // Event flags: a set in the same cycle as the clear wins.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_loss_flag_reg <= 1'b0;
         rx_wake_flag_reg <= 1'b0;
      end else begin
         lock_loss_flag_reg <= lock_lost || (lock_loss_flag_reg && !ack_clear); // RL6 RL7
         rx_wake_flag_reg <= (rx_wake_event_i && in_state_two_i && rx_fn_reg == RX_FN_RX_WAKE)
            || (rx_wake_flag_reg && !(wr_pf && !reg_wdata_i[PF_RX_WAKE_BIT])); // RL12
      end
   end

   assign div.divider = power_control_reg[PC_DIV_LSB +: PC_DIV_W];

   clk_divider #(.DIV_W(PC_DIV_W)) u_div (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .div(div)
   );

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
         core_clk_en_o <= 1'b0;
         meter_clk_en_o <= 1'b0;
         core_divider_field_o <= POWER_CONTROL_RESET[PC_DIV_LSB +: PC_DIV_W];
         metering_shutdown_o <= 1'b0;
         core_shutdown_o <= 1'b0;
         reference_keep_alive_o <= 1'b0;
         rx_pin_function_o <= RX_FN_GPIO;
         time_write_en_o <= 1'b0;
         mcu_reset_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_re_i ? rdata_next : 8'h00;
         core_clk_en_o <= div.core_tick; // RL1
         meter_clk_en_o <= div.meter_tick; // RL3
         core_divider_field_o <= div.divider; // RL1
         metering_shutdown_o <= power_control_reg[PC_METER_BIT]; // RL9
         core_shutdown_o <= power_control_reg[PC_CORE_OFF_BIT] && in_state_one_i; // RL10
         reference_keep_alive_o <= ref_keep_reg && in_state_two_i; // RL15
         rx_pin_function_o <= rx_fn_reg; // RL17
         time_write_en_o <= time_ok; // RL5
         mcu_reset_o <= lock_lost; // RL6
      end
   end
endmodule : clk_pwr_ctrl

// file: tb/clk_pwr_ctrl_sva.sv
// Port-level concurrent checks for the clock and power control block.
`timescale 1ns/10ps
module clk_pwr_ctrl_sva (
   // Watched inputs.
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic pll_locked_i,
   input wire logic in_state_one_i,
   input wire logic in_state_two_i,
   input wire logic time_reg_sel_i,
   // Watched outputs.
   input wire logic core_clk_en_o,
   input wire logic meter_clk_en_o,
   input wire logic [2:0] core_divider_field_o,
   input wire logic metering_shutdown_o,
   input wire logic core_shutdown_o,
   input wire logic reference_keep_alive_o,
   input wire logic time_write_en_o,
   input wire logic mcu_reset_o
);
   logic [7:0] wd_q1;
   logic [7:0] wd_q2;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Two stages, because the control outputs settle two edges after the write is taken.
   always_ff @(posedge core_clk_i) begin
      wd_q1 <= reg_wdata_i;
      wd_q2 <= wd_q1;
   end
   sequence key_s(k);
      reg_we_i && reg_addr_i == 8'hc1 && reg_wdata_i == k;
   endsequence
   sequence pc_s;
      reg_we_i && reg_addr_i == 8'hc5;
   endsequence
   sequence tk_s;
      reg_we_i && time_reg_sel_i;
   endsequence
   a_meter_rate: assert property (
      meter_clk_en_o |=> (!meter_clk_en_o) [*4] ##1 meter_clk_en_o) else $error("meter gap");
   a_core_full: assert property (
      (core_divider_field_o == 3'h0) [*3] |-> core_clk_en_o) else $error("core tick");
   a_power_unlock: assert property (key_s(8'ha7) ##1 pc_s |=> ##1
      core_divider_field_o == wd_q2[2:0] && metering_shutdown_o == wd_q2[6]) else $error("pc");
   a_key_used: assert property (
      pc_s ##1 pc_s |=> ##1 $stable(core_divider_field_o)) else $error("key reused");
   a_time_grant: assert property (
      key_s(8'hea) ##1 tk_s |=> time_write_en_o) else $error("no grant");
   a_time_refuse: assert property (
      tk_s ##1 tk_s |=> !time_write_en_o) else $error("bad grant");
   a_lock_reset: assert property (
      pll_locked_i ##1 !pll_locked_i |=> mcu_reset_o) else $error("no reset");
   a_core_gate: assert property (
      !in_state_one_i |=> !core_shutdown_o) else $error("core off");
   a_ref_gate: assert property (
      !in_state_two_i |=> !reference_keep_alive_o) else $error("ref on");
endmodule : clk_pwr_ctrl_sva

// file: tb/pll_lock_model.sv
// Crystal and PLL lock model: lock after a short settle, lost on command.
`timescale 1ns/10ps
module pll_lock_model #(
   parameter int SETTLE = 4
) (
   input wire logic core_clk_i,
   input wire logic lose_i,
   output logic pll_locked_o
);
   int cnt = 0;
   always @(posedge core_clk_i) cnt <= lose_i ? 0 : (cnt < SETTLE ? cnt + 1 : cnt);
   assign pll_locked_o = (cnt == SETTLE);
endmodule : pll_lock_model

// file: tb/tb_clk_pwr_ctrl.sv
// Self-checking bench for the clock and power control block.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module tb_clk_pwr_ctrl;
   logic core_clk_i = 0, rst_b_i = 0, reg_we_i = 0, reg_re_i = 0, pll_locked_i, lose = 0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d, r;
   logic supply_on_main_i = 1, supply_ok_i = 1, rx_wake_event_i = 0, in_state_one_i = 0;
   logic in_state_two_i = 0, time_reg_sel_i = 0, core_clk_en_o, meter_clk_en_o;
   logic metering_shutdown_o, core_shutdown_o, reference_keep_alive_o, time_write_en_o;
   logic mcu_reset_o;
   logic [2:0] core_divider_field_o;
   logic [1:0] rx_pin_function_o;
   int miscompares = 0, comparisons = 0, n;
   always #12.5 core_clk_i = ~core_clk_i;
   pll_lock_model xtal (.core_clk_i(core_clk_i), .lose_i(lose), .pll_locked_o(pll_locked_i));
   clk_pwr_ctrl uut (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o),
      .pll_locked_i(pll_locked_i),
      .supply_on_main_i(supply_on_main_i),
      .supply_ok_i(supply_ok_i),
      .rx_wake_event_i(rx_wake_event_i),
      .in_state_one_i(in_state_one_i),
      .in_state_two_i(in_state_two_i),
      .time_reg_sel_i(time_reg_sel_i),
      .core_clk_en_o(core_clk_en_o),
      .meter_clk_en_o(meter_clk_en_o),
      .core_divider_field_o(core_divider_field_o),
      .metering_shutdown_o(metering_shutdown_o),
      .core_shutdown_o(core_shutdown_o),
      .reference_keep_alive_o(reference_keep_alive_o),
      .rx_pin_function_o(rx_pin_function_o),
      .time_write_en_o(time_write_en_o),
      .mcu_reset_o(mcu_reset_o)
   );
   task automatic step;
      @(posedge core_clk_i);
      #2;
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_we_i = 1;
      reg_addr_i = a;
      reg_wdata_i = v;
      step;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_re_i = 1;
      reg_addr_i = a;
      step;
      r = reg_rdata_o;
   endtask : rd
   task automatic nop;
      reg_we_i = 0;
      reg_re_i = 0;
      step;
   endtask : nop
   // Core ticks are measured edge to edge, so a stale divider shows up as a wrong gap.
   task automatic gap(input int e);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            step;
            n++;
         end while (core_clk_en_o !== 1'b1 && n < 300);
      end
      `CHK(n, e)
   endtask : gap
   task automatic close_out;
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   initial begin
      #500000;
      miscompares++;
      close_out;
   end
   initial begin
      void'($urandom(45));
      repeat (16) @(posedge core_clk_i);
      #2 rst_b_i = 1;
      rd(8'hc5);
      `CHK(r, 8'h82)
      rd(8'hf4);
      `CHK(r, 8'h60)
      nop;
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h07 : (i == 1) ? 8'hd8 : 8'($urandom) & 8'hdf;
         in_state_one_i = d[7];
         wr(8'hc1, 8'ha7);
         wr(8'hc5, d);
         wr(8'hc5, ~d);
         nop;
         `CHK(core_divider_field_o, d[2:0])
         `CHK(metering_shutdown_o, d[6])
         `CHK(core_shutdown_o, d[4] & d[7])
         rd(8'hc5);
         `CHK(r, d & 8'h57 | 8'h80)
         nop;
         gap(1 << d[2:0]);
      end
      wr(8'hc1, 8'hea);
      time_reg_sel_i = 1;
      wr(8'ha2, 8'h12);
      `CHK(time_write_en_o, 1'b1)
      wr(8'ha3, 8'h34);
      `CHK(time_write_en_o, 1'b0)
      time_reg_sel_i = 0;
      wr(8'hc1, 8'ha7);
      time_reg_sel_i = 1;
      wr(8'ha2, 8'h12);
      `CHK(time_write_en_o, 1'b0)
      time_reg_sel_i = 0;
      wr(8'hc1, 8'h00);
      nop;
      for (int i = 0; i < 3; i++) begin
         d = {4'h0, 1'($urandom), 1'b0, i == 2, i != 0};
         {in_state_two_i, supply_on_main_i, supply_ok_i} = 3'($urandom);
         wr(8'hf4, d);
         nop;
         `CHK(rx_pin_function_o, d[1:0])
         `CHK(reference_keep_alive_o, d[3] & in_state_two_i)
         rd(8'hf4);
         `CHK(r, {1'b0, supply_on_main_i, supply_ok_i, 1'b0, d[3:0]})
         nop;
      end
      in_state_two_i = 1;
      rx_wake_event_i = 1;
      step;
      rx_wake_event_i = 0;
      rd(8'hf4);
      `CHK(r[7], 1'b1)
      lose = 1;
      nop;
      step;
      `CHK(mcu_reset_o, 1'b1)
      rd(8'hf4);
      `CHK(r[4], 1'b1)
      nop;
      lose = 0;
      repeat (6) step;
      wr(8'hd8, 8'h80);
      nop;
      rd(8'hf4);
      `CHK(r[4], 1'b0)
      rd(8'hd8);
      `CHK(r, 8'h00)
      nop;
      close_out;
   end
endmodule : tb_clk_pwr_ctrl
bind clk_pwr_ctrl clk_pwr_ctrl_sva chk (
   .core_clk_i(core_clk_i),
   .rst_b_i(rst_b_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_we_i(reg_we_i),
   .pll_locked_i(pll_locked_i),
   .in_state_one_i(in_state_one_i),
   .in_state_two_i(in_state_two_i),
   .time_reg_sel_i(time_reg_sel_i),
   .core_clk_en_o(core_clk_en_o),
   .meter_clk_en_o(meter_clk_en_o),
   .core_divider_field_o(core_divider_field_o),
   .metering_shutdown_o(metering_shutdown_o),
   .core_shutdown_o(core_shutdown_o),
   .reference_keep_alive_o(reference_keep_alive_o),
   .time_write_en_o(time_write_en_o),
   .mcu_reset_o(mcu_reset_o)
);
